// >>> mpsni_pkg.sv
// Constants, types and coding tables for the MII PHY-side nibble interface
package mpsni_pkg;

  // ----------------------------------------------------------------
  // Clock rates and divider counts
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int MII_100_HZ  = 25_000_000;
  localparam int MII_10_HZ   = 2_500_000;
  // Longest half period, rounded down, never below one cycle
  localparam int HALF_100_RAW = CLK_HZ / (2 * MII_100_HZ);
  localparam int HALF_10_RAW  = CLK_HZ / (2 * MII_10_HZ);
  localparam logic [3:0] HALF_100 = (HALF_100_RAW < 1) ? 4'h1 : 4'(HALF_100_RAW);
  localparam logic [3:0] HALF_10  = (HALF_10_RAW < 1) ? 4'h1 : 4'(HALF_10_RAW);

  // ----------------------------------------------------------------
  // Code groups
  // ----------------------------------------------------------------
  localparam logic [4:0] SYM_IDLE = 5'h1f;
  localparam logic [4:0] SYM_J    = 5'h18;
  localparam logic [4:0] SYM_K    = 5'h11;
  localparam logic [4:0] SYM_T    = 5'h0d;
  localparam logic [4:0] SYM_R    = 5'h07;
  localparam logic [4:0] SYM_HALT = 5'h04;
  localparam logic [3:0] NIB_FALSE_CARRIER = 4'he;
  localparam logic [5:0] RX_ENTRY_IDLE     = 6'h00;
  localparam logic [1:0] RX_BUF_DEPTH      = 2'h2;

  // Width of the synchronised pin vector
  localparam int IN_W = 21;

  typedef enum logic [1:0] {RX_IDLE, RX_GOT_J, RX_FRAME, RX_GOT_T} mpsni_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} mpsni_tx_state_t;

  typedef struct packed {
    logic [IN_W-1:0]  in_s1;
    logic [IN_W-1:0]  in_s2;
    logic             sclk_s3;
    mpsni_rx_state_t  rx_state;
    logic [1:0][5:0]  buf_q;
    logic [1:0]       buf_cnt;
    logic             buf_wp;
    logic             buf_rp;
    logic             sym_ready;
    logic [3:0]       rx_div;
    logic             rx_clk;
    logic [3:0]       rxd;
    logic             rx_dv;
    logic             rx_er;
    logic             rx_oe_n;
    logic [3:0]       tx_div;
    logic             tx_clk;
    logic             tick_d1;
    logic             tick_d2;
    mpsni_tx_state_t  tx_state;
    logic [4:0]       tx_sym;
    logic             tx_sym_valid;
    logic             tx_active;
  } mpsni_state_t;

  localparam mpsni_state_t STATE_RESET = '{
    rx_state: RX_IDLE, tx_state: TX_IDLE, tx_sym: SYM_IDLE, rx_oe_n: 1'b1,
    default: '0};

  // ----------------------------------------------------------------
  // 4B/5B coding
  // ----------------------------------------------------------------
  function automatic logic [4:0] mpsni_enc(input logic [3:0] nib);
    logic [4:0] s;
    unique case (nib)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      4'hf: s = 5'h1d;
    endcase
    return s;
  endfunction

  // Returns {invalid, nibble}
  function automatic logic [4:0] mpsni_dec(input logic [4:0] sym);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 16; i++)
    begin
      if (mpsni_enc(4'(i)) == sym)
      begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

// >>> mpsni_top.sv
// PHY-side MII nibble interface: receive delimiting, clocks and transmit coding
// How it works
// RL1: Data valid rises only after J/K found
// RL2: Data valid drops on T/R or error
// RL3: Data valid changes only with receive clock
// RL4: Coding errors in frame raise receive error; the code raises it at 100M only
// RL5: False carrier raises receive error at 100M
// RL6: Receive error changes only with receive clock
// RL7: Float request high releases receive outputs
// RL8: Address zero acts as float request
// RL9: Transmit clock 2.5 or 25 MHz by speed; at 100M the code gives 20 MHz from the 40 MHz clock
// RL10: Transmit nibble bit zero is least significant
// RL11: Nibbles sampled on transmit clock rises
// RL12: MAC enables transmit only with valid nibbles
// RL13: Transmission starts with first enabled sample
// RL14: Dropping enable ends the transmission
// RL15: Transmit error ignored at 10M
// RL16: Transmit error at 100M sends invalid symbols
// RL17: Errored nibble becomes HALT code
// RL18: Test bit selects translation table symbols
// RL19: Receive clock 2.5 or 25 MHz by speed; at 100M the code gives 20 MHz from the 40 MHz clock
// RL20: Receive nibbles driven on receive clock rises
// RL21: Translation table is a module parameter
// RL22: Otherwise standard 4B/5B encoding applies
`timescale 1ns/1ps

module mpsni_top
  import mpsni_pkg::*;
#(
  parameter logic [15:0][4:0] INV_TABLE = {16{5'h00}}
)(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       rx_sym_clk_i,
  input  wire logic [4:0] rx_sym_i,
  input  wire logic       rx_sym_err_i,
  output logic            rx_sym_ready_o,
  input  wire logic       rx_outputs_float_request_i,
  input  wire logic [4:0] phy_addr_i,
  input  wire logic       speed_100_i,
  input  wire logic       inv_code_test_i,
  output logic            rx_clk_o,
  output logic [3:0]      rxd_o,
  output logic            rx_dv_o,
  output logic            rx_er_o,
  output logic            rx_oe_n_o,
  output logic            tx_clk_o,
  input  wire logic       tx_en_i,
  input  wire logic [3:0] txd_i,
  input  wire logic       tx_er_i,
  output logic [4:0]      tx_sym_o,
  output logic            tx_sym_valid_o,
  output logic            tx_active_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mpsni_state_t st_r;
  mpsni_state_t st_nxt;

  // Synchronised pin values, all taken from the second stage
  logic       sclk;
  logic [4:0] sym;
  logic       serr;
  logic       flt;
  logic       spd;
  logic       test;
  logic [4:0] addr;
  logic       ten;
  logic [3:0] txd;
  logic       ter;

  assign {sclk, sym, serr, flt, spd, test, addr, ten, txd, ter} = st_r.in_s2;

  // Half-period divider shared by both MII clocks; returns {clk, count}
  function automatic logic [4:0] div_step(input logic [3:0] cnt, input logic clk,
                                          input logic fast);
    logic [3:0] half;
    half = fast ? HALF_100 : HALF_10;
    if (cnt + 4'h1 >= half)
    begin
      return {~clk, 4'h0};
    end
    return {clk, 4'(cnt + 4'h1)};
  endfunction

  always_comb
  begin
    logic [4:0] dv;
    logic [4:0] dec;
    logic       sym_edge;
    logic       push;
    logic       pop;
    logic       rx_rise;
    logic [5:0] entry;
    logic [3:0] nib;
    st_nxt   = st_r;
    dv       = '0;
    dec      = '0;
    push     = 1'b0;
    pop      = 1'b0;
    entry    = RX_ENTRY_IDLE;
    nib      = '0;
    sym_edge = 1'b0;
    rx_rise  = 1'b0;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    st_nxt.in_s1   = {rx_sym_clk_i, rx_sym_i, rx_sym_err_i, rx_outputs_float_request_i,
                      speed_100_i, inv_code_test_i, phy_addr_i, tx_en_i, txd_i, tx_er_i};
    st_nxt.in_s2   = st_r.in_s1;
    st_nxt.sclk_s3 = sclk;
    sym_edge       = sclk & ~st_r.sclk_s3;

    // ----------------------------------------------------------------
    // MII clocks
    // ----------------------------------------------------------------
    dv = div_step(st_r.rx_div, st_r.rx_clk, spd);  // RL19
    st_nxt.rx_clk = dv[4];
    st_nxt.rx_div = dv[3:0];
    rx_rise = dv[4] & ~st_r.rx_clk;
    dv = div_step(st_r.tx_div, st_r.tx_clk, spd);  // RL9
    st_nxt.tx_clk  = dv[4];
    st_nxt.tx_div  = dv[3:0];
    // Delay the rise by the depth of the pin synchronisers
    st_nxt.tick_d1 = dv[4] & ~st_r.tx_clk;
    st_nxt.tick_d2 = st_r.tick_d1;

    // ----------------------------------------------------------------
    // Receive symbol decoding
    // ----------------------------------------------------------------
    // A symbol offered while the buffer is full is refused via the ready port
    if (sym_edge && st_r.sym_ready)
    begin
      push = 1'b1;
      dec  = mpsni_dec(sym);
      unique case (st_r.rx_state)
        RX_IDLE:
        begin
          if (sym == SYM_J)
          begin
            st_nxt.rx_state = RX_GOT_J;
          end
          else if (sym != SYM_IDLE)
          begin
            entry = {1'b0, spd, NIB_FALSE_CARRIER};  // RL5
          end
        end
        RX_GOT_J:
        begin
          if (sym == SYM_K)
          begin
            st_nxt.rx_state = RX_FRAME;  // RL1
          end
          else
          begin
            entry           = {1'b0, spd, NIB_FALSE_CARRIER};  // RL5
            st_nxt.rx_state = RX_IDLE;
          end
        end
        RX_FRAME:
        begin
          if (serr)
          begin
            st_nxt.rx_state = RX_IDLE;  // RL2
          end
          else if (sym == SYM_T)
          begin
            st_nxt.rx_state = RX_GOT_T;  // RL2
          end
          else
          begin
            entry = {1'b1, spd & dec[4], dec[3:0]};  // RL4
          end
        end
        RX_GOT_T:
        begin
          st_nxt.rx_state = RX_IDLE;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Two-entry buffer toward the MAC
    // ----------------------------------------------------------------
    // The MAC side drains only on receive clock rises, so at 10M it fills
    pop = rx_rise && (st_r.buf_cnt != 2'h0);
    if (rx_rise)
    begin
      st_nxt.rxd   = pop ? st_r.buf_q[st_r.buf_rp][3:0] : 4'h0;  // RL20
      st_nxt.rx_dv = pop ? st_r.buf_q[st_r.buf_rp][5] : 1'b0;  // RL3
      st_nxt.rx_er = pop ? st_r.buf_q[st_r.buf_rp][4] : 1'b0;  // RL6
    end
    if (pop)
    begin
      st_nxt.buf_rp = ~st_r.buf_rp;
    end
    if (push)
    begin
      st_nxt.buf_q[st_r.buf_wp] = entry;
      st_nxt.buf_wp             = ~st_r.buf_wp;
    end
    st_nxt.buf_cnt   = 2'(st_r.buf_cnt + {1'b0, push} - {1'b0, pop});
    st_nxt.sym_ready = st_nxt.buf_cnt != RX_BUF_DEPTH;
    st_nxt.rx_oe_n   = flt | (addr == 5'h00);  // RL7 RL8

    // ----------------------------------------------------------------
    // Transmit coding
    // ----------------------------------------------------------------
    st_nxt.tx_sym_valid = st_r.tick_d2;
    if (st_r.tick_d2)  // RL11
    begin
      nib = txd;  // RL10
      unique case (st_r.tx_state)
        TX_IDLE:
        begin
          st_nxt.tx_sym    = ten ? SYM_J : SYM_IDLE;  // RL13
          st_nxt.tx_active = ten;
          st_nxt.tx_state  = ten ? TX_K : TX_IDLE;
        end
        TX_K:
        begin
          st_nxt.tx_sym   = ten ? SYM_K : SYM_T;
          st_nxt.tx_state = ten ? TX_DATA : TX_R;
        end
        TX_DATA:
        begin
          if (!ten)
          begin
            st_nxt.tx_sym   = SYM_T;  // RL14
            st_nxt.tx_state = TX_R;
          end
          else if (test)
          begin
            st_nxt.tx_sym = INV_TABLE[nib];  // RL18 RL21
          end
          else if (ter && spd)  // RL15
          begin
            st_nxt.tx_sym = SYM_HALT;  // RL16 RL17
          end
          else
          begin
            st_nxt.tx_sym = mpsni_enc(nib);  // RL22
          end
        end
        TX_R:
        begin
          st_nxt.tx_sym    = SYM_R;  // RL14
          st_nxt.tx_active = 1'b0;
          st_nxt.tx_state  = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_r <= STATE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rx_sym_ready_o = st_r.sym_ready;
  assign rx_clk_o       = st_r.rx_clk;
  assign rxd_o          = st_r.rxd;
  assign rx_dv_o        = st_r.rx_dv;
  assign rx_er_o        = st_r.rx_er;
  assign rx_oe_n_o      = st_r.rx_oe_n;
  assign tx_clk_o       = st_r.tx_clk;
  assign tx_sym_o       = st_r.tx_sym;
  assign tx_sym_valid_o = st_r.tx_sym_valid;
  assign tx_active_o    = st_r.tx_active;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_end_delims;
    (tx_sym_valid_o && tx_sym_o == SYM_T) ##[1:40] (tx_sym_valid_o && tx_sym_o == SYM_R);
  endsequence

  property p_dv_on_rxclk;
    $changed(rx_dv_o) |-> $rose(rx_clk_o);
  endproperty
  a_dv_on_rxclk: assert property (p_dv_on_rxclk) else $error("rx_dv moved off clock rise"); // RL3

  property p_er_on_rxclk;
    $changed(rx_er_o) |-> $rose(rx_clk_o);
  endproperty
  a_er_on_rxclk: assert property (p_er_on_rxclk) else $error("rx_er moved off clock rise"); // RL6

  property p_float_req;
    flt |=> rx_oe_n_o;
  endproperty
  a_float_req: assert property (p_float_req) else $error("outputs driven under float"); // RL7

  property p_addr_zero;
    (addr == 5'h00) && !flt |=> rx_oe_n_o ##1 ($past(addr) != 5'h00 || rx_oe_n_o);
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address zero not floated"); // RL8

  property p_txclk_10;
    // A switch to 100M inside a half period legally cuts it short
    disable iff (reset_i || spd)
    $rose(tx_clk_o) && !spd && $stable(spd) |-> tx_clk_o [*8] ##1 !tx_clk_o;
  endproperty
  a_txclk_10: assert property (p_txclk_10) else $error("10M transmit clock half wrong"); // RL9

  property p_tx_start;
    st_r.tick_d2 && ten && st_r.tx_state == TX_IDLE |=> tx_sym_o == SYM_J && tx_active_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit did not start"); // RL13

  property p_tx_end;
    st_r.tick_d2 && !ten && st_r.tx_state == TX_DATA |=> s_end_delims ##1 !tx_active_o;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit did not end with T R"); // RL14

  property p_tx_halt;
    st_r.tick_d2 && st_r.tx_state == TX_DATA && ten && ter && spd && !test
      |=> tx_sym_o == SYM_HALT;
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("errored nibble not HALT"); // RL16 RL17

  property p_tx_10_plain;
    st_r.tick_d2 && st_r.tx_state == TX_DATA && ten && !spd && !test
      |=> tx_sym_o == mpsni_enc($past(txd));
  endproperty
  a_tx_10_plain: assert property (p_tx_10_plain) else $error("10M coding used tx_er"); // RL15 RL22

  property p_tx_table;
    st_r.tick_d2 && st_r.tx_state == TX_DATA && ten && test |=> tx_sym_o == INV_TABLE[$past(txd)];
  endproperty
  a_tx_table: assert property (p_tx_table) else $error("test table symbol missing"); // RL18

endmodule

// >>> mpsni_mac_model.sv
// MAC-side partner model: sends transmit nibbles and collects receive nibbles
`timescale 1ns/1ps

module mpsni_mac_model
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       tx_clk_i,
  input  wire logic       rx_clk_i,
  input  wire logic [3:0] rxd_i,
  input  wire logic       rx_dv_i,
  input  wire logic       rx_er_i,
  output logic            tx_en_o,
  output logic [3:0]      txd_o,
  output logic            tx_er_o
);
  logic [4:0] tx_q[$];
  logic [4:0] rx_q[$];
  logic [4:0] w;
  logic       clk_q    = 1'h0;
  logic       dv_q     = 1'h0;
  logic       er_q     = 1'h0;
  int         fc_cnt   = 0;
  int         sync_err = 0;

  initial
  begin
    tx_en_o = 1'h0;
    txd_o = 4'h0;
    tx_er_o = 1'h0;
  end

  // ------------------------------------------------------------
  // Transmit and receive sides
  // ------------------------------------------------------------
  // A new nibble goes out just after each transmit clock rise
  always @(posedge tx_clk_i)
  begin
    @(negedge clk_i);
    if (tx_q.size() > 0)
    begin
      w = tx_q.pop_front();
      tx_en_o = 1'h1;
      txd_o = w[3:0];
      tx_er_o = w[4];
    end
    else
    begin
      tx_en_o = 1'h0;
      tx_er_o = 1'h0;
      // Idle lines keep toggling so a stale nibble never passes for data
      txd_o = ~txd_o;
    end
  end

  // Sample on receive clock rise; a change of rx_dv or rx_er off that edge, out of reset, is counted
  always @(posedge clk_i)
  begin
    if (rx_clk_i === 1'h1 && clk_q === 1'h0)
    begin
      if (rx_dv_i === 1'h1)
        rx_q.push_back({rx_er_i, rxd_i});
      else if (rx_er_i === 1'h1)
        fc_cnt++;
    end
    else if (reset_i === 1'h0 && (rx_dv_i !== dv_q || rx_er_i !== er_q))
      sync_err++;
    clk_q = rx_clk_i;
    dv_q = rx_dv_i;
    er_q = rx_er_i;
  end
endmodule

// >>> mpsni_top_tb.sv
// Self-checking bench for the MII PHY-side nibble interface
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module mpsni_top_tb;
  import mpsni_pkg::*;

  typedef struct packed {
    logic       s;
    logic       t;
    logic       e;
    logic [3:0] n;
    logic [4:0] x;
  } mpsni_row_t;

  // ------------------------------------------------------------
  // Rows: speed, test bit, error, nibble, expected symbol
  // ------------------------------------------------------------
  mpsni_row_t rows[16] = '{
    '{1'h1,1'h0,1'h0,4'h0,5'h1e}, '{1'h1,1'h0,1'h0,4'h1,5'h09},
    '{1'h0,1'h0,1'h0,4'h2,5'h14}, '{1'h1,1'h0,1'h1,4'h3,5'h04},
    '{1'h1,1'h0,1'h0,4'h4,5'h0a}, '{1'h0,1'h0,1'h1,4'h5,5'h0b},
    '{1'h1,1'h0,1'h0,4'h6,5'h0e}, '{1'h1,1'h0,1'h0,4'h7,5'h0f},
    '{1'h0,1'h0,1'h0,4'h8,5'h12}, '{1'h1,1'h1,1'h0,4'h9,5'h19},
    '{1'h1,1'h0,1'h0,4'ha,5'h16}, '{1'h1,1'h0,1'h0,4'hb,5'h17},
    '{1'h1,1'h1,1'h1,4'hc,5'h03}, '{1'h0,1'h0,1'h0,4'hd,5'h1b},
    '{1'h1,1'h0,1'h0,4'he,5'h1c}, '{1'h1,1'h0,1'h0,4'hf,5'h1d}};

  logic       clk  = 1'h0;
  logic       rst  = 1'h1;
  logic       sclk = 1'h0;
  logic [4:0] sym  = 5'h1f;
  logic       serr = 1'h0;
  logic       flt  = 1'h0;
  logic [4:0] addr = 5'h03;
  logic       spd  = 1'h1;
  logic       tst  = 1'h0;
  logic       rdy, rxc, dv, er, oen, txc, ten, ter, tval, tact, low_seen;
  logic [3:0] rxd, txd;
  logic [4:0] tsym;
  logic [5:0] txs[$];
  logic [5:0] want[$];
  int         checked     = 0;
  int         miscompares = 0;
  int         n, p, fc0;

  // Odd and even nibbles map to different test symbols
  mpsni_top #(.INV_TABLE({8{5'h19, 5'h03}})) mpsni_top_i (
    .clk_i(clk), .reset_i(rst), .rx_sym_clk_i(sclk), .rx_sym_i(sym), .rx_sym_err_i(serr),
    .rx_sym_ready_o(rdy), .rx_outputs_float_request_i(flt), .phy_addr_i(addr),
    .speed_100_i(spd), .inv_code_test_i(tst), .rx_clk_o(rxc), .rxd_o(rxd), .rx_dv_o(dv),
    .rx_er_o(er), .rx_oe_n_o(oen), .tx_clk_o(txc), .tx_en_i(ten), .txd_i(txd),
    .tx_er_i(ter), .tx_sym_o(tsym), .tx_sym_valid_o(tval), .tx_active_o(tact));

  mpsni_mac_model mac_i (
    .clk_i(clk), .reset_i(rst), .tx_clk_i(txc), .rx_clk_i(rxc), .rxd_i(rxd),
    .rx_dv_i(dv), .rx_er_i(er), .tx_en_o(ten), .txd_o(txd), .tx_er_o(ter));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (tval === 1'h1 && tsym !== SYM_IDLE)
      txs.push_back({tact, tsym});
    if (rdy === 1'h0)
      low_seen = 1'h1;
  end

  function automatic logic pick(input bit w);
    return w ? rxc : txc;
  endfunction

  // Cycles between two rises of the chosen clock output
  task automatic per(input bit w, output int pr);
    logic q;
    int   r1;
    q = 1'h1;
    r1 = -1;
    pr = 0;
    for (int c = 0; c < 60; c++)
    begin
      @(posedge clk);
      if (pick(w) === 1'h1 && q === 1'h0)
      begin
        if (r1 >= 0 && pr == 0)
          pr = c - r1;
        r1 = c;
      end
      q = pick(w);
    end
  endtask

  // Symbol edge only once the buffer can take it, so a stall loses nothing
  task automatic send(input logic [5:0] q[$]);
    int c;
    foreach (q[i])
    begin
      @(negedge clk);
      sym = q[i][4:0];
      serr = q[i][5];
      #100;
      c = 0;
      while (rdy !== 1'h1 && c < 500)
      begin
        @(negedge clk);
        c++;
      end
      sclk = 1'h1;
      #100;
      sclk = 1'h0;
    end
  endtask

  task automatic wait_clk(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    `CHK("watchdog", 1'h0, 1'h1)
    finish_test;
  end

  initial
  begin
    wait_clk(8);
    rst = 1'h0;
    wait_clk(4);
    foreach (rows[i])
    begin
      spd = rows[i].s;
      tst = rows[i].t;
      wait_clk(40);
      txs.delete();
      mac_i.tx_q = '{5'h05, 5'h05, {rows[i].e, rows[i].n}};
      n = 0;
      while (txs.size() < 5 && n < 3000)
      begin
        @(negedge clk);
        n++;
      end
      want = '{6'h38, 6'h31, {1'h1, rows[i].x}, 6'h2d, 6'h07};
      foreach (want[k]) `CHK("tx_sym", want[k], txs[k])
      if (!rows[i].t && !(rows[i].e && rows[i].s))
      begin
        mac_i.rx_q.delete();
        send('{6'h1f, 6'h18, 6'h11, {1'h0, rows[i].x}, 6'h0d, 6'h07, 6'h1f});
        wait_clk(300);
        `CHK("rx_cnt", 1, mac_i.rx_q.size())
        `CHK("rx_nib", {1'h0, rows[i].n}, mac_i.rx_q[0])
      end
      $display("test row %0d done", i);
    end
    for (int s = 0; s < 2; s++)
    begin
      spd = s[0];
      wait_clk(40);
      per(1'h0, p);
      `CHK("tx_period", 2 * (s ? HALF_100 : HALF_10), p)
      per(1'h1, p);
      `CHK("rx_period", 2 * (s ? HALF_100 : HALF_10), p)
    end
    $display("test clocks done");
    mac_i.rx_q.delete();
    fc0 = mac_i.fc_cnt;
    send('{6'h1f, 6'h0e, 6'h1f, 6'h1f});
    wait_clk(100);
    `CHK("false_carrier", 1'h1, mac_i.fc_cnt > fc0)
    `CHK("fc_no_dv", 0, mac_i.rx_q.size())
    send('{6'h18, 6'h11, 6'h00, 6'h0d, 6'h07, 6'h1f});
    wait_clk(100);
    `CHK("bad_code", 5'h10, mac_i.rx_q[0])
    mac_i.rx_q.delete();
    send('{6'h18, 6'h11, 6'h09, 6'h2e, 6'h0a, 6'h0d, 6'h07, 6'h1f});
    wait_clk(100);
    `CHK("sig_err_cnt", 1, mac_i.rx_q.size())
    `CHK("sig_err_nib", 5'h01, mac_i.rx_q[0])
    $display("test receive errors done");
    spd = 1'h0;
    wait_clk(40);
    mac_i.rx_q.delete();
    low_seen = 1'h0;
    send('{6'h18, 6'h11, 6'h1e, 6'h09, 6'h14, 6'h15, 6'h0a, 6'h0b, 6'h0d, 6'h07, 6'h1f});
    wait_clk(300);
    `CHK("buf_stall", 1'h1, low_seen)
    `CHK("buf_cnt", 6, mac_i.rx_q.size())
    for (int k = 0; k < 6; k++) `CHK("buf_nib", 5'(k), mac_i.rx_q[k])
    $display("test buffer done");
    flt = 1'h1;
    wait_clk(10);
    `CHK("float", 1'h1, oen)
    flt = 1'h0;
    wait_clk(10);
    `CHK("drive", 1'h0, oen)
    addr = 5'h00;
    wait_clk(10);
    `CHK("addr_zero", 1'h1, oen)
    addr = 5'h03;
    $display("test float done");
    rst = 1'h1;
    wait_clk(3);
    `CHK("reset_out", 13'h07e0, {dv, er, oen, tsym, tval, tact, rdy, rxc, txc})
    rst = 1'h0;
    wait_clk(1);
    `CHK("rdy_edge1", 1'h1, rdy)
    wait_clk(1);
    `CHK("rdy_edge2", 1'h1, rdy)
    `CHK("rx_sync", 0, mac_i.sync_err)
    $display("test reset done");
    finish_test;
  end
endmodule
